// ---- verilog/evtrig_pkg.sv ----
// Constants, types and state layout of the debug event trigger block
package evtrig_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REG_AW = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_A_ADDR = 8'h04;
    localparam logic [7:0] OFS_A_CFG = 8'h08;
    localparam logic [7:0] OFS_A_DATA = 8'h0C;
    localparam logic [7:0] OFS_B_ADDR = 8'h10;
    localparam logic [7:0] OFS_B_CFG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IMASK = 8'h1C;
    localparam logic [7:0] OFS_STATE = 8'h20;

    // Control register fields
    localparam int CTRL_BRK_LSB = 0;
    localparam int CTRL_HALT_FULL = 3;
    localparam int CTRL_TTYPE = 4;
    localparam int CTRL_START_LSB = 5;
    localparam int CTRL_STOP_LSB = 8;
    localparam int CTRL_PICK = 11;

    // Event configuration fields
    localparam int CFG_AMASK_LSB = 0;
    localparam int CFG_SIZE_LSB = 5;
    localparam int CFG_DIR_LSB = 7;
    localparam int CFG_DATA_EN = 9;
    localparam int DATA_MASK_LSB = 16;

    // Data mask limits per access size
    localparam logic [15:0] BYTE_LIMIT = 16'h00FF;
    localparam logic [15:0] WORD_LIMIT = 16'hFFFF;

    // Status bits, shared by the interrupt mask
    localparam int NSTAT = 5;
    localparam int ST_HIT_A = 0;
    localparam int ST_HIT_B = 1;
    localparam int ST_BREAK = 2;
    localparam int ST_TSTART = 3;
    localparam int ST_TSTOP = 4;
    localparam logic [4:0] RST_STAT = 5'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {SZ_ANY, SZ_BYTE, SZ_WORD} size_e;
    typedef enum logic [1:0] {DIR_RW, DIR_RD, DIR_WR} dir_e;
    typedef enum logic [2:0] {C_NONE, C_A, C_A_OR_B, C_A_AND_B,
                              C_B_THEN_A} cond_e;
    typedef enum logic [2:0] {SP_BREAK, SP_FULL, SP_A, SP_A_OR_B,
                              SP_A_AND_B, SP_B_THEN_A} stop_e;
    typedef enum logic {TT_BRANCH, TT_DATA} ttype_e;
    typedef enum logic {PK_A, PK_A_OR_B} pick_e;

    // One monitored data access
    typedef struct packed {
        logic valid;
        logic write;
        logic word;
        logic [23:0] addr;
        logic [15:0] data;
    } acc_s;

    // One match event setting
    typedef struct packed {
        logic [23:0] addr;
        logic [4:0] amask;
        size_e size;
        dir_e dir;
        logic data_en;
        logic [15:0] dval;
        logic [15:0] dmask;
    } evcfg_s;

    // Whole state of the trigger block
    typedef struct packed {
        cond_e brk;
        logic halt_full;
        ttype_e ttype;
        cond_e start;
        stop_e stop;
        pick_e pick;
        evcfg_s eva;
        evcfg_s evb;
        logic [4:0] stat;
        logic [4:0] imask;
        logic seen_a;
        logic seen_b;
        logic tracing;
        logic full_prev;
        logic halt_prev;
        logic brk_out;
        logic rec;
        logic hit_a;
        logic hit_b;
        logic [31:0] rdata;
    } st_s;

endpackage : evtrig_pkg

// ---- verilog/evtrig.sv ----
// Debug event comparators with break and trace qualifier logic
`timescale 1ns/10ps
module evtrig (
    input wire logic clk,
    input wire logic rst_n,
    input wire evtrig_pkg::acc_s acc,
    input wire logic branch_valid,
    input wire logic run_start,
    input wire logic cpu_halted,
    input wire logic trace_full,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic break_req,
    output logic trace_active,
    output logic trace_record,
    output logic event_a,
    output logic event_b,
    output logic irq
);
    import evtrig_pkg::*;

    st_s s_q;
    st_s s_d;
    logic hit_a;
    logic hit_b;
    logic brk_ev;
    logic start_ev;
    logic stop_ev;
    logic pick_ok;
    logic [4:0] set_bits;

    ////////////////////////////////////////////////////////////////////
    // Comparator for one event on the current access
    function automatic logic ev_match(evcfg_s c, acc_s a, logic use_data);
        logic [23:0] am;
        logic [15:0] dm;
        logic addr_ok;
        logic size_ok;
        logic dir_ok;
        logic data_ok;
        am = ~((24'h00_0001 << c.amask) - 24'h00_0001);
        addr_ok = ((a.addr ^ c.addr) & am) == 24'h00_0000;
        unique case (c.size)
            SZ_BYTE: size_ok = !a.word;
            SZ_WORD: size_ok = a.word;
            default: size_ok = 1'b1;
        endcase
        unique case (c.dir)
            DIR_RD: dir_ok = !a.write;
            DIR_WR: dir_ok = a.write;
            default: dir_ok = 1'b1;
        endcase
        // Mask is cut to the width of the access
        dm = c.dmask & (a.word ? WORD_LIMIT : BYTE_LIMIT);
        data_ok = !use_data || !c.data_en || (dm == 16'h0000) ||
                  (((a.data ^ c.dval) & dm) == 16'h0000);
        return a.valid && addr_ok && size_ok && dir_ok && data_ok;
    endfunction : ev_match

    // Combined condition on current hits and earlier occurrences
    function automatic logic cond_met(cond_e c, logic ha, logic hb,
                                      logic sa, logic sb);
        logic r;
        unique case (c)
            C_NONE: r = 1'b0;
            C_A: r = ha;
            C_A_OR_B: r = ha | hb;
            // Fires on the hit that completes the pair
            C_A_AND_B: r = (ha | hb) & (ha | sa) & (hb | sb);
            C_B_THEN_A: r = ha & sb;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : cond_met

    ////////////////////////////////////////////////////////////////////
    // Event detection and qualifiers
    always_comb begin
        hit_a = ev_match(s_q.eva, acc, 1'b1);
        hit_b = ev_match(s_q.evb, acc, 1'b0);
        brk_ev = cond_met(s_q.brk, hit_a, hit_b, s_q.seen_a,
                          s_q.seen_b) |
                 (s_q.halt_full & trace_full & !s_q.full_prev);
        // A start setting of none means start on run
        start_ev = (s_q.start == C_NONE) ? run_start :
                   cond_met(s_q.start, hit_a, hit_b, s_q.seen_a,
                            s_q.seen_b);
        unique case (s_q.stop)
            SP_BREAK: stop_ev = (cpu_halted & !s_q.halt_prev) |
                                brk_ev;
            SP_FULL: stop_ev = trace_full;
            SP_A: stop_ev = hit_a;
            SP_A_OR_B: stop_ev = hit_a | hit_b;
            SP_A_AND_B: stop_ev = cond_met(C_A_AND_B, hit_a, hit_b,
                                           s_q.seen_a, s_q.seen_b);
            SP_B_THEN_A: stop_ev = hit_a & s_q.seen_b;
            default: stop_ev = 1'b0;
        endcase
        pick_ok = (s_q.pick == PK_A) ? hit_a : (hit_a | hit_b);
        set_bits = {stop_ev & s_q.tracing, start_ev & !s_q.tracing,
                    brk_ev, hit_b, hit_a};
    end

    ////////////////////////////////////////////////////////////////////
    // Next state: registers, flags, trace state and read data
    always_comb begin
        s_d = s_q;
        s_d.full_prev = trace_full;
        s_d.halt_prev = cpu_halted;
        s_d.hit_a = hit_a;
        s_d.hit_b = hit_b;
        s_d.brk_out = brk_ev;
        s_d.rdata = RST_WORD;
        // Occurrence flags; a new run starts from clean flags
        if (run_start) begin
            s_d.seen_a = 1'b0;
            s_d.seen_b = 1'b0;
        end else begin
            s_d.seen_a = s_q.seen_a | hit_a;
            s_d.seen_b = s_q.seen_b | hit_b;
        end
        // Trace window; stop wins over a start in the same cycle
        if (stop_ev) begin
            s_d.tracing = 1'b0;
        end else if (start_ev) begin
            s_d.tracing = 1'b1;
        end
        // One recording kind at a time
        if (s_q.ttype == TT_BRANCH) begin
            s_d.rec = s_q.tracing & !stop_ev & branch_valid;
        end else begin
            s_d.rec = s_q.tracing & !stop_ev & pick_ok;
        end
        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_CTRL: begin
                    s_d.brk = cond_e'(reg_wdata[CTRL_BRK_LSB +: 3]);
                    s_d.halt_full = reg_wdata[CTRL_HALT_FULL];
                    s_d.ttype = ttype_e'(reg_wdata[CTRL_TTYPE]);
                    s_d.start = cond_e'(reg_wdata[CTRL_START_LSB +: 3]);
                    s_d.stop = stop_e'(reg_wdata[CTRL_STOP_LSB +: 3]);
                    s_d.pick = pick_e'(reg_wdata[CTRL_PICK]);
                end
                OFS_A_ADDR: s_d.eva.addr = reg_wdata[23:0];
                OFS_B_ADDR: s_d.evb.addr = reg_wdata[23:0];
                OFS_A_CFG: begin
                    s_d.eva.amask = reg_wdata[CFG_AMASK_LSB +: 5];
                    s_d.eva.size = size_e'(reg_wdata[CFG_SIZE_LSB +: 2]);
                    s_d.eva.dir = dir_e'(reg_wdata[CFG_DIR_LSB +: 2]);
                    s_d.eva.data_en = reg_wdata[CFG_DATA_EN];
                end
                OFS_B_CFG: begin
                    s_d.evb.amask = reg_wdata[CFG_AMASK_LSB +: 5];
                    s_d.evb.size = size_e'(reg_wdata[CFG_SIZE_LSB +: 2]);
                    s_d.evb.dir = dir_e'(reg_wdata[CFG_DIR_LSB +: 2]);
                end
                OFS_A_DATA: begin
                    s_d.eva.dval = reg_wdata[15:0];
                    s_d.eva.dmask = reg_wdata[DATA_MASK_LSB +: 16];
                end
                OFS_IMASK: s_d.imask = reg_wdata[4:0];
                default: ;
            endcase
        end
        // Sticky status: a new event wins over a write-one clear
        if (reg_wr && reg_addr == OFS_STATUS) begin
            s_d.stat = (s_q.stat & ~reg_wdata[4:0]) | set_bits;
        end else begin
            s_d.stat = s_q.stat | set_bits;
        end
        // Read data stands only in the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL: s_d.rdata = {20'h0_0000, s_q.pick, s_q.stop,
                                       s_q.start, s_q.ttype,
                                       s_q.halt_full, s_q.brk};
                OFS_A_ADDR: s_d.rdata = {8'h00, s_q.eva.addr};
                OFS_B_ADDR: s_d.rdata = {8'h00, s_q.evb.addr};
                OFS_A_CFG: s_d.rdata = {22'h00_0000, s_q.eva.data_en,
                                        s_q.eva.dir, s_q.eva.size,
                                        s_q.eva.amask};
                OFS_B_CFG: s_d.rdata = {23'h00_0000, s_q.evb.dir,
                                        s_q.evb.size, s_q.evb.amask};
                OFS_A_DATA: s_d.rdata = {s_q.eva.dmask, s_q.eva.dval};
                OFS_STATUS: s_d.rdata = {27'h000_0000, s_q.stat};
                OFS_IMASK: s_d.rdata = {27'h000_0000, s_q.imask};
                OFS_STATE: s_d.rdata = {28'h000_0000, s_q.brk_out,
                                        s_q.tracing, s_q.seen_b,
                                        s_q.seen_a};
                default: s_d.rdata = RST_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state
    assign reg_rdata = s_q.rdata;
    assign break_req = s_q.brk_out;
    assign trace_active = s_q.tracing;
    assign trace_record = s_q.rec;
    assign event_a = s_q.hit_a;
    assign event_b = s_q.hit_b;
    assign irq = |(s_q.stat & s_q.imask);

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Address bits above the masked range must agree
    property p_addr;
        acc.valid && s_q.eva.amask == 5'h00 &&
        acc.addr != s_q.eva.addr |=> !event_a;
    endproperty
    a_addr: assert property (p_addr) else $error("bad addr hit");

    // Unmasked data difference blocks a hit
    property p_data;
        acc.valid && s_q.eva.data_en && s_q.eva.dmask[0] &&
        acc.data[0] != s_q.eva.dval[0] |=> !event_a;
    endproperty
    a_data: assert property (p_data) else $error("data ignored");

    // Zero mask never raises event A without a hit
    property p_nodata;
        s_q.eva.dmask == 16'h0000 && hit_a == 1'b0 |=> !event_a;
    endproperty
    a_nodata: assert property (p_nodata) else $error("spurious A");

    // Size filter
    property p_size;
        s_q.evb.size == SZ_WORD && acc.valid && !acc.word |=> !event_b;
    endproperty
    a_size: assert property (p_size) else $error("size ignored");

    // Direction filter
    property p_dir;
        s_q.eva.dir == DIR_RD && acc.write |=> !event_a;
    endproperty
    a_dir: assert property (p_dir) else $error("dir ignored");

    // Sequential break needs an earlier B
    property p_seq;
        s_q.brk == C_B_THEN_A && !s_q.seen_b && !s_q.halt_full
        |=> !break_req;
    endproperty
    a_seq: assert property (p_seq) else $error("early seq break");

    // Both-events break needs A and B seen
    property p_and;
        break_req && $past(s_q.brk) == C_A_AND_B && !$past(s_q.halt_full)
        |-> s_q.seen_a && s_q.seen_b;
    endproperty
    a_and: assert property (p_and) else $error("early and break");

    // Full buffer raises a break when enabled
    property p_full;
        s_q.halt_full && !s_q.full_prev ##0 trace_full |=> break_req;
    endproperty
    a_full: assert property (p_full) else $error("no full break");

    // Break stop ends tracing within one cycle of the halt
    property p_stop;
        s_q.stop == SP_BREAK && cpu_halted && !s_q.halt_prev
        |=> !trace_active;
    endproperty
    a_stop: assert property (p_stop) else $error("trace not stopped");

    // Records only while the window is open
    property p_rec;
        trace_record |-> $past(s_q.tracing);
    endproperty
    a_rec: assert property (p_rec) else $error("record outside");

    // Run start clears the flags
    property p_clr;
        run_start |=> !s_q.seen_a && !s_q.seen_b;
    endproperty
    a_clr: assert property (p_clr) else $error("flags kept");

    c_seq: cover property (event_b ##[1:20] break_req);
    c_trace: cover property (trace_active ##1 trace_record ##[1:20]
                             !trace_active);
    c_irq: cover property (irq ##1 !irq);

endmodule : evtrig

// ---- verif/cpu_bus_model.sv ----
// Model of the monitored processor data bus and its run control
`timescale 1ns/10ps
module cpu_bus_model (
    input wire logic clk,
    input wire logic break_req,
    output evtrig_pkg::acc_s acc,
    output logic branch_valid,
    output logic run_start,
    output logic cpu_halted,
    output logic trace_full
);
    import evtrig_pkg::*;

    logic run_req;

    initial begin
        acc = '0;
        branch_valid = 1'b0;
        run_start = 1'b0;
        cpu_halted = 1'b0;
        trace_full = 1'b0;
        run_req = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Core halts on a break request and resumes on a run command
    always @(posedge clk) begin
        run_start <= run_req;
        if (break_req) begin
            cpu_halted <= 1'b1;
        end else if (run_req) begin
            cpu_halted <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One data access; k is {write, word}, lines scrambled after it
    task automatic access(input logic [1:0] k, input logic [23:0] a,
                          input logic [15:0] d);
        acc_s x;
        x = '{1'b1, k[1], k[0], a, d};
        @(posedge clk);
        acc <= x;
        @(posedge clk);
        x = ~x;
        x.valid = 1'b0;
        acc <= x;
        #1;
    endtask : access

    // Start the target program
    task automatic run();
        @(posedge clk);
        run_req <= 1'b1;
        @(posedge clk);
        run_req <= 1'b0;
        @(posedge clk);
        #1;
    endtask : run

    // One branch to be recorded
    task automatic branch();
        @(posedge clk);
        branch_valid <= 1'b1;
        @(posedge clk);
        branch_valid <= 1'b0;
        #1;
    endtask : branch

    // Trace storage full level
    task automatic set_full(input logic v);
        @(posedge clk);
        trace_full <= v;
    endtask : set_full

endmodule : cpu_bus_model

// ---- verif/tb_evtrig.sv ----
// Self-checking bench for the debug event trigger block
`timescale 1ns/10ps
module tb_evtrig;
    import evtrig_pkg::*;

    typedef struct packed {
        logic [11:0] ctrl;
        logic [9:0] cfg;
        logic [31:0] dat;
        logic [1:0] k;
        logic [23:0] adr;
        logic [15:0] dv;
        logic [2:0] ex;
    } row_s;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    acc_s acc;
    logic branch_valid, run_start, cpu_halted, trace_full;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic break_req, trace_active, trace_record, event_a, event_b, irq;
    int errors = 0;
    int total_checks = 0;
    logic hit;

    // Rows: control, A config, A data, access, expected {a, b, break}
    row_s rows[12] = '{
        '{12'h001, 10'h340, 32'h00FF0012, 2'h3, 24'h420, 16'h5512, 3'h5},
        '{12'h001, 10'h340, 32'h00FF0012, 2'h3, 24'h420, 16'h5534, 3'h0},
        '{12'h001, 10'h340, 32'h00000012, 2'h3, 24'h420, 16'h5534, 3'h5},
        '{12'h001, 10'h320, 32'hFFFF0012, 2'h2, 24'h420, 16'h5512, 3'h5},
        '{12'h001, 10'h040, 32'h0, 2'h2, 24'h420, 16'h0, 3'h0},
        '{12'h001, 10'h020, 32'h0, 2'h3, 24'h420, 16'h0, 3'h0},
        '{12'h001, 10'h080, 32'h0, 2'h2, 24'h420, 16'h0, 3'h0},
        '{12'h001, 10'h003, 32'h0, 2'h2, 24'h427, 16'h0, 3'h5},
        '{12'h001, 10'h003, 32'h0, 2'h2, 24'h428, 16'h0, 3'h0},
        '{12'h002, 10'h000, 32'h0, 2'h0, 24'h403, 16'h0, 3'h3},
        '{12'h002, 10'h000, 32'h0, 2'h2, 24'h403, 16'h0, 3'h0},
        '{12'h000, 10'h000, 32'h0, 2'h2, 24'h420, 16'h0, 3'h4}
    };

    evtrig dut (.clk(clk), .rst_n(rst_n), .acc(acc),
        .branch_valid(branch_valid), .run_start(run_start),
        .cpu_halted(cpu_halted), .trace_full(trace_full),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .break_req(break_req),
        .trace_active(trace_active), .trace_record(trace_record),
        .event_a(event_a), .event_b(event_b), .irq(irq));

    cpu_bus_model cpu (.clk(clk), .break_req(break_req), .acc(acc),
        .branch_valid(branch_valid), .run_start(run_start),
        .cpu_halted(cpu_halted), .trace_full(trace_full));

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Compare, register port and verdict helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic close_out();
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // Watchdog
    initial begin
        #100000;
        errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({break_req, trace_active, trace_record, irq}, 32'h0);
        rd(OFS_CTRL, 32'h0);
        rd(8'h40, 32'h0);
        wr(OFS_A_ADDR, 32'h420);
        wr(OFS_B_ADDR, 32'h400);
        wr(OFS_B_CFG, 32'h82);
        foreach (rows[i]) begin
            wr(OFS_CTRL, {20'h0, rows[i].ctrl});
            wr(OFS_A_CFG, {22'h0, rows[i].cfg});
            wr(OFS_A_DATA, rows[i].dat);
            cpu.access(rows[i].k, rows[i].adr, rows[i].dv);
            chk({event_a, event_b, break_req}, rows[i].ex);
        end
        // Conjunctive break, flags cleared by a new run
        wr(OFS_A_CFG, 32'h0);
        wr(OFS_CTRL, 32'h3);
        cpu.run();
        cpu.access(2'h2, 24'h420, 16'h0);
        chk(break_req, 32'h0);
        cpu.access(2'h0, 24'h401, 16'h0);
        chk(break_req, 32'h1);
        cpu.run();
        cpu.access(2'h0, 24'h401, 16'h0);
        chk(break_req, 32'h0);
        // Sequential break
        wr(OFS_CTRL, 32'h4);
        cpu.run();
        cpu.access(2'h2, 24'h420, 16'h0);
        chk(break_req, 32'h0);
        cpu.access(2'h0, 24'h402, 16'h0);
        chk(break_req, 32'h0);
        cpu.access(2'h2, 24'h420, 16'h0);
        chk(break_req, 32'h1);
        // Break on full trace storage
        wr(OFS_CTRL, 32'h8);
        cpu.set_full(1'b1);
        hit = 1'b0;
        repeat (3) begin
            @(posedge clk);
            #1;
            hit = hit | break_req;
        end
        chk(hit, 32'h1);
        cpu.set_full(1'b0);
        // Branch trace from run to break
        wr(OFS_CTRL, 32'h1);
        cpu.run();
        chk(trace_active, 32'h1);
        cpu.branch();
        chk(trace_record, 32'h1);
        cpu.access(2'h2, 24'h420, 16'h0);
        repeat (2) @(posedge clk);
        #1;
        chk(trace_active, 32'h0);
        // Data trace pick-up
        wr(OFS_CTRL, 32'h10);
        cpu.run();
        cpu.access(2'h0, 24'h403, 16'h0);
        chk(trace_record, 32'h0);
        cpu.access(2'h2, 24'h420, 16'h0);
        chk(trace_record, 32'h1);
        wr(OFS_CTRL, 32'h810);
        cpu.access(2'h0, 24'h403, 16'h0);
        chk(trace_record, 32'h1);
        // Stop on event A
        wr(OFS_CTRL, 32'h210);
        cpu.run();
        cpu.access(2'h0, 24'h403, 16'h0);
        chk(trace_active, 32'h1);
        cpu.access(2'h2, 24'h420, 16'h0);
        chk(trace_active, 32'h0);
        // Start on event A
        wr(OFS_CTRL, 32'h20);
        cpu.run();
        chk(trace_active, 32'h0);
        cpu.access(2'h2, 24'h420, 16'h0);
        chk(trace_active, 32'h1);
        // Stop on full storage
        wr(OFS_CTRL, 32'h100);
        cpu.run();
        cpu.set_full(1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk(trace_active, 32'h0);
        cpu.set_full(1'b0);
        // Interrupt: raise, mask, clear
        wr(OFS_CTRL, 32'h0);
        wr(OFS_STATUS, 32'h1F);
        wr(OFS_IMASK, 32'h1);
        #1;
        chk(irq, 32'h0);
        cpu.access(2'h2, 24'h420, 16'h0);
        @(posedge clk);
        #1;
        chk(irq, 32'h1);
        wr(OFS_IMASK, 32'h0);
        #1;
        chk(irq, 32'h0);
        wr(OFS_IMASK, 32'h1);
        wr(OFS_STATUS, 32'h1);
        @(posedge clk);
        #1;
        chk(irq, 32'h0);
        close_out();
    end

endmodule : tb_evtrig
